// ===== rtl/pitc_cfg.svh
`ifndef PITC_CFG_SVH
`define PITC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PITC_P1_CTL_OFS 8'h10
`define PITC_P2_CTL_OFS 8'h20
`define PITC_P3_CTL_OFS 8'h30
`define PITC_MAP_LO_OFS 8'h0c
`define PITC_MAP_HI_OFS 8'h0d

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define PITC_STORM_BIT 7
`define PITC_DSCP_BIT 6
`define PITC_P1P_BIT 5
`define PITC_PRIO_MSB 4
`define PITC_PRIO_LSB 3
`define PITC_INS_BIT 2
`define PITC_REM_BIT 1
`define PITC_SPLIT_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PITC_CTL_RESET 8'h01
`define PITC_MAP_LO_RESET 8'h50
`define PITC_MAP_HI_RESET 8'hfa

`endif

// ===== rtl/pitc_classifier.sv
`default_nettype none
module pitc_classifier (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Settings
	input wire pitc_pkg::pitc_ctl_type ctl_i,
	input wire logic [15:0] tag_priority_map_field_i,
	// Ingress packet descriptor
	input wire logic ing_valid_i,
	input wire logic ing_broadcast_i,
	input wire logic storm_limit_hit_i,
	input wire logic ing_ipv4_i,
	input wire logic ing_dscp_hit_i,
	input wire logic [1:0] ing_dscp_prio_i,
	input wire logic ing_tagged_i,
	input wire logic [2:0] ing_tag_prio_i,
	// Classification result
	output logic cls_valid_o,
	output logic [1:0] cls_queue_o,
	output logic cls_drop_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [1:0] queue;
		logic drop;
	} pitc_cls_state_type;

	pitc_cls_state_type state_reg;
	pitc_cls_state_type state_next;

	always_comb begin
		logic use_dscp;
		logic use_p1p;
		logic [1:0] p1p_prio;
		logic [1:0] dscp_prio;
		use_dscp = ctl_i.dscp_en && ing_ipv4_i && ing_dscp_hit_i;
		use_p1p = ctl_i.p1p_en && ing_tagged_i;
		p1p_prio = use_p1p ? tag_priority_map_field_i[{ing_tag_prio_i, 1'b0} +: 2] : 2'h0;
		dscp_prio = use_dscp ? ing_dscp_prio_i : 2'h0;
		state_next.valid = ing_valid_i;
		if (use_dscp || use_p1p) begin
			state_next.queue = p1p_prio | dscp_prio;
		end else begin
			state_next.queue = ctl_i.port_prio;
		end
		state_next.drop = ing_valid_i && ctl_i.storm_en && ing_broadcast_i
			&& storm_limit_hit_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_reg <= '0;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign cls_valid_o = state_reg.valid;
	assign cls_queue_o = state_reg.queue;
	assign cls_drop_o = state_reg.drop;

endmodule : pitc_classifier
`default_nettype wire

// ===== rtl/pitc_pkg.sv
`default_nettype none
package pitc_pkg;

	// ----------------------------------------
	// Decoded port control
	// ----------------------------------------
	typedef struct packed {
		logic storm_en;
		logic dscp_en;
		logic p1p_en;
		logic [1:0] port_prio;
		logic tag_insert;
		logic tag_remove;
		logic four_queue_split_enable;
	} pitc_ctl_type;

	typedef logic [7:0] pitc_byte_type;

endpackage : pitc_pkg
`default_nettype wire

// ===== rtl/pitc_tag_map.sv
`include "pitc_cfg.svh"
`default_nettype none
module pitc_tag_map (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Register access
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	// Map contents
	output logic [15:0] tag_priority_map_field_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		pitc_pkg::pitc_byte_type map_lo;
		pitc_pkg::pitc_byte_type map_hi;
	} pitc_map_state_type;

	pitc_map_state_type state_reg;
	pitc_map_state_type state_next;

	always_comb begin
		state_next = state_reg;
		if (reg_wr_i && reg_addr_i == `PITC_MAP_LO_OFS) begin
			state_next.map_lo = reg_wdata_i;
		end
		if (reg_wr_i && reg_addr_i == `PITC_MAP_HI_OFS) begin
			state_next.map_hi = reg_wdata_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_reg.map_lo <= `PITC_MAP_LO_RESET;
			state_reg.map_hi <= `PITC_MAP_HI_RESET;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign tag_priority_map_field_o = {state_reg.map_hi, state_reg.map_lo};

endmodule : pitc_tag_map
`default_nettype wire

// ===== rtl/pitc_top.sv
`include "pitc_cfg.svh"
`default_nettype none
module pitc_top (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	// Register access
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Two-queue split bits of each port's second control register
	input wire logic [2:0] two_queue_split_i,
	output logic [2:0] split_conflict_o,
	// Ingress descriptors, one slice per port
	input wire logic [2:0] ing_valid_i,
	input wire logic [2:0] ing_broadcast_i,
	input wire logic [2:0] storm_limit_hit_i,
	input wire logic [2:0] ing_ipv4_i,
	input wire logic [2:0] ing_dscp_hit_i,
	input wire logic [5:0] ing_dscp_prio_i,
	input wire logic [2:0] ing_tagged_i,
	input wire logic [8:0] ing_tag_prio_i,
	// Classification results, one slice per port
	output logic [2:0] cls_valid_o,
	output logic [5:0] cls_queue_o,
	output logic [2:0] cls_drop_o,
	// Egress descriptors, one slice per egress port
	input wire logic [2:0] egr_valid_i,
	input wire logic [2:0] egr_rx_tagged_i,
	input wire logic [5:0] egr_src_port_i,
	input wire logic [5:0] egr_queue_i,
	input wire logic [35:0] port_default_vlan_id_i,
	// Egress actions, one slice per egress port
	output logic [2:0] egr_valid_o,
	output logic [2:0] egr_insert_tag_o,
	output logic [2:0] egr_remove_tag_o,
	output logic [35:0] egr_insert_vid_o,
	output logic [5:0] egr_tx_queue_o,
	// Static per-port settings
	output logic [2:0] storm_enable_o,
	output logic [2:0] dscp_enable_o,
	output logic [2:0] p1p_enable_o,
	output logic [5:0] port_priority_o,
	output logic [2:0] tag_insert_enable_o,
	output logic [2:0] tag_remove_enable_o,
	output logic [2:0] four_queue_split_enable_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		pitc_pkg::pitc_byte_type [2:0] ctl;
		logic [7:0] rdata;
		logic rvalid;
		logic [2:0] egr_valid;
		logic [2:0] egr_insert;
		logic [2:0] egr_remove;
		logic [35:0] egr_vid;
		logic [5:0] egr_queue;
	} pitc_top_state_type;

	pitc_top_state_type state_reg;
	pitc_top_state_type state_next;

	logic [15:0] map_field;
	pitc_pkg::pitc_ctl_type [2:0] ctl_dec;

	// ----------------------------------------
	// 802.1p map registers
	// ----------------------------------------
	pitc_tag_map u_tag_map (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i),
		.tag_priority_map_field_o(map_field)
	);

	// ----------------------------------------
	// Per-port decode and classification
	// ----------------------------------------
	genvar p;
	generate
		for (p = 0; p < 3; p = p + 1) begin : g_port
			assign ctl_dec[p].storm_en = state_reg.ctl[p][`PITC_STORM_BIT];
			assign ctl_dec[p].dscp_en = state_reg.ctl[p][`PITC_DSCP_BIT];
			assign ctl_dec[p].p1p_en = state_reg.ctl[p][`PITC_P1P_BIT];
			assign ctl_dec[p].port_prio = state_reg.ctl[p][`PITC_PRIO_MSB:`PITC_PRIO_LSB];
			assign ctl_dec[p].tag_insert = state_reg.ctl[p][`PITC_INS_BIT];
			assign ctl_dec[p].tag_remove = state_reg.ctl[p][`PITC_REM_BIT];
			assign ctl_dec[p].four_queue_split_enable = state_reg.ctl[p][`PITC_SPLIT_BIT];

			pitc_classifier u_cls (
				.core_clk_i(core_clk_i),
				.reset_i(reset_i),
				.ce_i(ce_i),
				.ctl_i(ctl_dec[p]),
				.tag_priority_map_field_i(map_field),
				.ing_valid_i(ing_valid_i[p]),
				.ing_broadcast_i(ing_broadcast_i[p]),
				.storm_limit_hit_i(storm_limit_hit_i[p]),
				.ing_ipv4_i(ing_ipv4_i[p]),
				.ing_dscp_hit_i(ing_dscp_hit_i[p]),
				.ing_dscp_prio_i(ing_dscp_prio_i[2*p +: 2]),
				.ing_tagged_i(ing_tagged_i[p]),
				.ing_tag_prio_i(ing_tag_prio_i[3*p +: 3]),
				.cls_valid_o(cls_valid_o[p]),
				.cls_queue_o(cls_queue_o[2*p +: 2]),
				.cls_drop_o(cls_drop_o[p])
			);

			assign storm_enable_o[p] = ctl_dec[p].storm_en;
			assign dscp_enable_o[p] = ctl_dec[p].dscp_en;
			assign p1p_enable_o[p] = ctl_dec[p].p1p_en;
			assign port_priority_o[2*p +: 2] = ctl_dec[p].port_prio;
			assign tag_insert_enable_o[p] = ctl_dec[p].tag_insert;
			assign tag_remove_enable_o[p] = ctl_dec[p].tag_remove;
			assign four_queue_split_enable_o[p] = ctl_dec[p].four_queue_split_enable;
			// Flags a setting that software must avoid
			assign split_conflict_o[p] = ctl_dec[p].four_queue_split_enable
				&& two_queue_split_i[p];
		end
	endgenerate

	// ----------------------------------------
	// Register writes, reads and egress actions
	// ----------------------------------------
	always_comb begin
		logic [1:0] src;
		src = 2'h0;
		state_next = state_reg;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`PITC_P1_CTL_OFS: state_next.ctl[0] = reg_wdata_i;
				`PITC_P2_CTL_OFS: state_next.ctl[1] = reg_wdata_i;
				`PITC_P3_CTL_OFS: state_next.ctl[2] = reg_wdata_i;
				default: state_next.ctl = state_reg.ctl;
			endcase
		end
		state_next.rvalid = reg_rd_i;
		case (reg_addr_i)
			`PITC_P1_CTL_OFS: state_next.rdata = state_reg.ctl[0];
			`PITC_P2_CTL_OFS: state_next.rdata = state_reg.ctl[1];
			`PITC_P3_CTL_OFS: state_next.rdata = state_reg.ctl[2];
			`PITC_MAP_LO_OFS: state_next.rdata = map_field[7:0];
			`PITC_MAP_HI_OFS: state_next.rdata = map_field[15:8];
			default: state_next.rdata = 8'h00;
		endcase
		if (!reg_rd_i) begin
			state_next.rdata = state_reg.rdata;
		end
		for (int e = 0; e < 3; e++) begin
			src = egr_src_port_i[2*e +: 2];
			state_next.egr_valid[e] = egr_valid_i[e];
			state_next.egr_insert[e] = egr_valid_i[e] && ctl_dec[e].tag_insert
				&& !egr_rx_tagged_i[e];
			state_next.egr_remove[e] = egr_valid_i[e] && ctl_dec[e].tag_remove
				&& egr_rx_tagged_i[e];
			case (src)
				2'h1: state_next.egr_vid[12*e +: 12] = port_default_vlan_id_i[23:12];
				2'h2: state_next.egr_vid[12*e +: 12] = port_default_vlan_id_i[35:24];
				default: state_next.egr_vid[12*e +: 12] = port_default_vlan_id_i[11:0];
			endcase
			state_next.egr_queue[2*e +: 2] = ctl_dec[e].four_queue_split_enable
				? egr_queue_i[2*e +: 2] : 2'h0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_reg <= '0;
			state_reg.ctl[0] <= `PITC_CTL_RESET;
			state_reg.ctl[1] <= `PITC_CTL_RESET;
			state_reg.ctl[2] <= `PITC_CTL_RESET;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_o = state_reg.rdata;
	assign reg_rvalid_o = state_reg.rvalid;
	assign egr_valid_o = state_reg.egr_valid;
	assign egr_insert_tag_o = state_reg.egr_insert;
	assign egr_remove_tag_o = state_reg.egr_remove;
	assign egr_insert_vid_o = state_reg.egr_vid;
	assign egr_tx_queue_o = state_reg.egr_queue;

endmodule : pitc_top
`default_nettype wire

// ===== testbench/pitc_top_checker.sv
`default_nettype none
module pitc_top_checker (
	// Clock and register access
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_rvalid_o,
	// Ingress
	input wire logic [2:0] ing_valid_i,
	input wire logic [2:0] ing_broadcast_i,
	input wire logic [2:0] storm_limit_hit_i,
	input wire logic [2:0] cls_drop_o,
	// Egress
	input wire logic [2:0] egr_valid_i,
	input wire logic [2:0] egr_rx_tagged_i,
	input wire logic [5:0] egr_src_port_i,
	input wire logic [35:0] port_default_vlan_id_i,
	input wire logic [2:0] egr_insert_tag_o,
	input wire logic [2:0] egr_remove_tag_o,
	input wire logic [35:0] egr_insert_vid_o,
	// Settings
	input wire logic [2:0] two_queue_split_i,
	input wire logic [2:0] split_conflict_o,
	input wire logic [2:0] storm_enable_o,
	input wire logic [5:0] port_priority_o,
	input wire logic [2:0] tag_insert_enable_o,
	input wire logic [2:0] tag_remove_enable_o,
	input wire logic [2:0] four_queue_split_enable_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	rd_answer_a: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	write_prio_a: assert property (ce_i && reg_wr_i && reg_addr_i == 8'h20
		|=> port_priority_o[3:2] == $past(reg_wdata_i[4:3])) else $error("priority not written");
	storm_drop_a: assert property (ce_i && ing_valid_i[0] && ing_broadcast_i[0]
		&& storm_limit_hit_i[0] && storm_enable_o[0] |=> cls_drop_o[0]) else $error("no drop");
	no_storm_a: assert property (ce_i && ing_valid_i[2] && !storm_enable_o[2]
		|=> !cls_drop_o[2]) else $error("drop while storm off");
	tag_insert_a: assert property (ce_i && egr_valid_i[1] |=> egr_insert_tag_o[1]
		== $past(tag_insert_enable_o[1] && !egr_rx_tagged_i[1])) else $error("insert wrong");
	tag_remove_a: assert property (ce_i && egr_valid_i[1] |=> egr_remove_tag_o[1]
		== $past(tag_remove_enable_o[1] && egr_rx_tagged_i[1])) else $error("remove wrong");
	ingress_vid_a: assert property (ce_i && egr_valid_i[1] && egr_src_port_i[3:2] == 2'h2
		|=> egr_insert_vid_o[23:12] == $past(port_default_vlan_id_i[35:24]))
		else $error("vid wrong");
	split_flag_a: assert property (split_conflict_o ==
		(four_queue_split_enable_o & two_queue_split_i)) else $error("conflict flag wrong");
	reset_load_a: assert property ($fell(reset_i) |-> four_queue_split_enable_o == 3'h7
		&& port_priority_o == 6'h00 && storm_enable_o == 3'h0) else $error("reset value wrong");
endmodule : pitc_top_checker

bind pitc_top pitc_top_checker u_chk (.*);
`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	typedef struct {
		int p;
		logic [7:0] ctl;
		logic tg;
		logic [2:0] tp;
		logic v4;
		logic hit;
		logic [1:0] dp;
		logic [1:0] q;
	} pitc_row_type;
	logic core_clk_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
	logic [2:0] two_queue_split_i = 3'h0, ing_valid_i = 3'h0, ing_broadcast_i = 3'h0;
	logic [2:0] storm_limit_hit_i = 3'h0, ing_ipv4_i = 3'h0, ing_dscp_hit_i = 3'h0;
	logic [2:0] ing_tagged_i = 3'h0, egr_valid_i = 3'h0, egr_rx_tagged_i = 3'h0;
	logic [5:0] ing_dscp_prio_i = 6'h00, egr_src_port_i = 6'h00, egr_queue_i = 6'h00;
	logic [8:0] ing_tag_prio_i = 9'h000;
	logic [35:0] port_default_vlan_id_i = 36'h321abc456;
	logic [2:0] split_conflict_o, cls_valid_o, cls_drop_o, egr_valid_o, egr_insert_tag_o;
	logic [2:0] egr_remove_tag_o, storm_enable_o, dscp_enable_o, p1p_enable_o;
	logic reg_rvalid_o;
	logic [2:0] tag_insert_enable_o, tag_remove_enable_o, four_queue_split_enable_o;
	logic [5:0] cls_queue_o, egr_tx_queue_o, port_priority_o;
	logic [35:0] egr_insert_vid_o;
	int err_total = 0;
	int total_checks = 0;
	pitc_row_type rows [8] = '{
		'{1, 8'h19, 1'b0, 3'h0, 1'b0, 1'b0, 2'h0, 2'h3},
		'{1, 8'h3f, 1'b1, 3'h2, 1'b0, 1'b0, 2'h0, 2'h1},
		'{2, 8'h41, 1'b0, 3'h0, 1'b1, 1'b1, 2'h2, 2'h2},
		'{2, 8'h71, 1'b1, 3'h4, 1'b1, 1'b1, 2'h1, 2'h3},
		'{1, 8'h28, 1'b0, 3'h0, 1'b1, 1'b1, 2'h3, 2'h1},
		'{2, 8'hc8, 1'b0, 3'h0, 1'b1, 1'b0, 2'h3, 2'h1},
		'{0, 8'hb6, 1'b1, 3'h7, 1'b0, 1'b0, 2'h0, 2'h3},
		'{2, 8'h51, 1'b0, 3'h0, 1'b0, 1'b1, 2'h3, 2'h2}};
	pitc_top dut (.*);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge core_clk_i);
		reg_wr_i = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge core_clk_i);
		reg_rd_i = 1'b0;
		chk(reg_rvalid_o, 1'b1);
		chk(reg_rdata_o, exp);
	endtask : rd
	task automatic ing(input pitc_row_type r);
		@(negedge core_clk_i);
		ing_valid_i[r.p] = 1'b1;
		ing_tagged_i[r.p] = r.tg;
		ing_tag_prio_i[r.p*3 +: 3] = r.tp;
		ing_ipv4_i[r.p] = r.v4;
		ing_dscp_hit_i[r.p] = r.hit;
		ing_dscp_prio_i[r.p*2 +: 2] = r.dp;
		@(negedge core_clk_i);
		ing_valid_i = 3'h0;
		chk(cls_valid_o[r.p], 1'b1);
		chk(cls_queue_o[r.p*2 +: 2], r.q);
	endtask : ing
	task automatic egr(input logic tg, input logic [1:0] src, input logic [3:0] exp);
		@(negedge core_clk_i);
		egr_valid_i[1] = 1'b1;
		egr_rx_tagged_i[1] = tg;
		egr_src_port_i[3:2] = src;
		egr_queue_i[3:2] = 2'h3;
		@(negedge core_clk_i);
		egr_valid_i = 3'h0;
		chk({egr_valid_o[1], egr_insert_tag_o[1], egr_remove_tag_o[1]}, {1'b1, exp[3:2]});
		chk(egr_tx_queue_o[3:2], exp[1:0]);
	endtask : egr
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		forever #50 core_clk_i = ~core_clk_i;
	end
	initial begin
		repeat (20000) @(posedge core_clk_i);
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(negedge core_clk_i);
		reset_i = 1'b0;
		chk({storm_enable_o, port_priority_o, tag_insert_enable_o}, 12'h000);
		chk(four_queue_split_enable_o, 3'h7);
		rd(8'h30, 8'h01);
		rd(8'h0c, 8'h50);
		rd(8'h0d, 8'hfa);
		rd(8'h25, 8'h00);
		$display("reset test done");
		foreach (rows[i]) begin
			int p;
			p = rows[i].p;
			wr(8'h10 * 8'(p + 1), rows[i].ctl);
			rd(8'h10 * 8'(p + 1), rows[i].ctl);
			chk({storm_enable_o[p], dscp_enable_o[p], p1p_enable_o[p], port_priority_o[p*2 +: 2],
				tag_insert_enable_o[p], tag_remove_enable_o[p], four_queue_split_enable_o[p]},
				rows[i].ctl);
			ing(rows[i]);
		end
		$display("table test done");
		ing_broadcast_i = 3'h5;
		storm_limit_hit_i = 3'h5;
		ing(rows[6]);
		chk(cls_drop_o[0], 1'b1);
		ing(rows[7]);
		chk(cls_drop_o[2], 1'b0);
		ing_broadcast_i = 3'h0;
		wr(8'h0d, 8'h4e);
		ing('{0, 8'h00, 1'b1, 3'h5, 1'b0, 1'b0, 2'h0, 2'h3});
		ing('{0, 8'h00, 1'b1, 3'h7, 1'b0, 1'b0, 2'h0, 2'h1});
		$display("storm and map test done");
		wr(8'h20, 8'h06);
		egr(1'b0, 2'h2, 4'h8);
		chk(egr_insert_vid_o[23:12], 12'h321);
		egr(1'b1, 2'h0, 4'h4);
		wr(8'h20, 8'h01);
		egr(1'b0, 2'h1, 4'h3);
		$display("egress test done");
		two_queue_split_i = 3'h7;
		@(negedge core_clk_i);
		chk(split_conflict_o, 3'h6);
		two_queue_split_i = 3'h0;
		ce_i = 1'b0;
		wr(8'h30, 8'hff);
		ce_i = 1'b1;
		rd(8'h30, 8'h51);
		reset_i = 1'b1;
		@(negedge core_clk_i);
		reset_i = 1'b0;
		rd(8'h30, 8'h01);
		$display("control test done");
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
